// >>> ttm_regs.vh
// Constants for the tape transport motion and format block
`ifndef TTM_REGS_VH
`define TTM_REGS_VH
`define TTM_CLK_NS        8
`define TTM_BRAKE_MS      100
// Brake length in system clocks: 100 ms at 8 ns, sized to the counter
`define TTM_BRAKE_CYCLES  24'd12500000
`define TTM_BRAKE_W       24
`define TTM_MARK_W        6
`define TTM_DATA_W        3
`define TTM_CTRL_FRAMES   3'd6
`define TTM_DATA_FRAMES   3'd4
`define TTM_JOG_HOLD      2'd0
`define TTM_JOG_FWD       2'd1
`define TTM_JOG_REV       2'd2
`endif

// >>> ttm_mark_check.v
// Mark code symmetry check plus frame counter
`timescale 1ns/1ns
module ttm_mark_check (
    input  wire       clk,          // System clock
    input  wire       rst,          // Synchronous reset
    input  wire       frame_en,     // One frame strobe
    input  wire [5:0] mark_code,    // Assembled mark code
    output reg        mark_ok_reg,  // Code valid and symmetric
    output reg  [2:0] frame_cnt_reg // Frames in current word
);
    // Reverse bit order and complement, as seen reading backwards
    function [5:0] rev_view;
        input [5:0] c;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                rev_view[i] = ~c[5 - i];
        end
    endfunction

    // Valid codes are symmetric; every such code has three ones, so one flipped
    // bit always breaks the symmetry and can never land on another valid code
    always @(posedge clk) begin
        if (rst) begin
            mark_ok_reg   <= 1'b0;
            frame_cnt_reg <= 3'h0;
        end else if (frame_en) begin
            mark_ok_reg   <= (rev_view(mark_code) == mark_code);
            frame_cnt_reg <= (frame_cnt_reg == 3'h5) ? 3'h0 : frame_cnt_reg + 3'h1;
        end
    end
endmodule

// >>> ttm_top.v
// Tape transport manual motion logic and track format front end
`timescale 1ns/1ns
`include "ttm_regs.vh"
module ttm_top (
    input  wire       CLK_SYS,       // 125 MHz system clock
    input  wire       SYS_RST,       // Synchronous reset, active high
    input  wire       MODE_LOCAL,    // Mode selector in local position
    input  wire [1:0] JOG_SWITCH,    // 0 hold, 1 forward, 2 reverse
    input  wire       WRITE_ENABLE,  // Protect switch allows writing
    input  wire       WRITE_MODE,    // Transport is writing
    input  wire       TIMING_IN,     // Timing channel from head
    input  wire       MARK_IN,       // Mark channel from head
    input  wire [2:0] DATA_IN,       // Data channels from heads (read)
    input  wire [2:0] DATA_WR,       // Data channels from controller (write)
    output reg        WRITE_ECHO,    // High when writing permitted
    output reg        TIMING_POS,    // Positive timing transition pulse
    output reg        TIMING_NEG,    // Negative timing transition pulse
    output reg  [2:0] DATA_OUT,      // Read data to controller
    output reg  [5:0] MARK_CODE,     // Last six mark bits
    output reg        MARK_VALID,    // Mark code is a valid symmetric code
    output reg  [2:0] FRAME_COUNT,   // Frame index within word
    output reg  [5:0] COIL_A,        // Write drive, first coil of each pair
    output reg  [5:0] COIL_B,        // Write drive, second coil of each pair
    output reg        MOTION_ACTIVE, // Motion flip-flop
    output reg        DIRECTION_FWD, // Direction flip-flop, high forward
    output reg        FWD_RUN,       // Forward motor run
    output reg        FWD_DRAG,      // Forward motor drag
    output reg        FWD_BRAKE,     // Forward motor brake
    output reg        REV_RUN,       // Reverse motor run
    output reg        REV_DRAG,      // Reverse motor drag
    output reg        REV_BRAKE      // Reverse motor brake
);
    // Two-stage synchronisers for all pin inputs except SYS_RST
    reg        local_s1_reg, local_s2_reg;
    reg  [1:0] jog_s1_reg, jog_s2_reg;
    reg        wen_s1_reg, wen_s2_reg;
    reg        tim_s1_reg, tim_s2_reg, tim_d_reg;
    reg        mark_s1_reg, mark_s2_reg;
    reg  [2:0] din_s1_reg, din_s2_reg;
    reg  [2:0] dwr_s1_reg, dwr_s2_reg;
    reg        wm_s1_reg, wm_s2_reg;
    reg  [`TTM_BRAKE_W-1:0] brake_cnt_reg;
    reg        motion_next, dir_next;
    wire       mark_ok;
    wire [2:0] frame_cnt;
    wire       tim_rise, tim_fall, fwd_cmd, rev_cmd, hold_cmd, brake_on;

    always @(posedge CLK_SYS) begin
        local_s1_reg <= MODE_LOCAL;
        local_s2_reg <= local_s1_reg;
        jog_s1_reg   <= JOG_SWITCH;
        jog_s2_reg   <= jog_s1_reg;
        wen_s1_reg   <= WRITE_ENABLE;
        wen_s2_reg   <= wen_s1_reg;
        tim_s1_reg   <= TIMING_IN;
        tim_s2_reg   <= tim_s1_reg;
        tim_d_reg    <= tim_s2_reg;
        mark_s1_reg  <= MARK_IN;
        mark_s2_reg  <= mark_s1_reg;
        din_s1_reg   <= DATA_IN;
        din_s2_reg   <= din_s1_reg;
        dwr_s1_reg   <= DATA_WR;
        dwr_s2_reg   <= dwr_s1_reg;
        wm_s1_reg    <= WRITE_MODE;
        wm_s2_reg    <= wm_s1_reg;
    end

    // Timing edges; the falling edge paces the mark shift and frame count
    assign tim_rise = tim_s2_reg & ~tim_d_reg;
    assign tim_fall = ~tim_s2_reg & tim_d_reg;

    // Jog decode, gated by the local mode selector
    assign fwd_cmd  = local_s2_reg && (jog_s2_reg == `TTM_JOG_FWD);
    assign rev_cmd  = local_s2_reg && (jog_s2_reg == `TTM_JOG_REV);
    assign hold_cmd = local_s2_reg && (jog_s2_reg == `TTM_JOG_HOLD);
    assign brake_on = (brake_cnt_reg != {`TTM_BRAKE_W{1'b0}});

    // Next state of motion and direction flip-flops
    always @* begin
        motion_next = MOTION_ACTIVE;
        dir_next    = DIRECTION_FWD;
        if (fwd_cmd) begin
            motion_next = 1'b1;
            dir_next    = 1'b1;
        end else if (rev_cmd) begin
            motion_next = 1'b1;
            dir_next    = 1'b0;
        end else if (hold_cmd) begin
            motion_next = 1'b0;
        end
    end

    // Motion, direction and brake one-shot
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            MOTION_ACTIVE <= 1'b0;
            DIRECTION_FWD <= 1'b1;
            brake_cnt_reg <= {`TTM_BRAKE_W{1'b0}};
        end else begin
            MOTION_ACTIVE <= motion_next;
            DIRECTION_FWD <= dir_next;
            if (motion_next)
                brake_cnt_reg <= {`TTM_BRAKE_W{1'b0}};
            else if (MOTION_ACTIVE)
                brake_cnt_reg <= `TTM_BRAKE_CYCLES;
            else if (brake_on)
                brake_cnt_reg <= brake_cnt_reg - 1'b1;
        end
    end

    // Motor drive from next state so outputs track the flip-flops
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            FWD_RUN   <= 1'b0;
            REV_RUN   <= 1'b0;
            FWD_DRAG  <= 1'b1;
            REV_DRAG  <= 1'b1;
            FWD_BRAKE <= 1'b0;
            REV_BRAKE <= 1'b0;
        end else begin
            FWD_RUN   <= motion_next & dir_next;
            REV_RUN   <= motion_next & ~dir_next;
            REV_DRAG  <= motion_next ? dir_next : ~(MOTION_ACTIVE | brake_on);
            FWD_DRAG  <= motion_next ? ~dir_next : ~(MOTION_ACTIVE | brake_on);
            REV_BRAKE <= ~motion_next & (MOTION_ACTIVE | brake_on) & dir_next;
            FWD_BRAKE <= ~motion_next & (MOTION_ACTIVE | brake_on) & ~dir_next;
        end
    end

    // Write echo, timing pulses, read data and coil drive
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            WRITE_ECHO <= 1'b0;
            TIMING_POS <= 1'b0;
            TIMING_NEG <= 1'b0;
            DATA_OUT   <= 3'h0;
            MARK_CODE  <= 6'h00;
            COIL_A     <= 6'h00;
            COIL_B     <= 6'h00;
        end else begin
            WRITE_ECHO <= wen_s2_reg;
            TIMING_POS <= tim_rise;
            TIMING_NEG <= tim_fall;
            DATA_OUT   <= din_s2_reg;
            if (tim_fall)
                MARK_CODE <= {MARK_CODE[4:0], mark_s2_reg};
            if (wm_s2_reg && wen_s2_reg) begin
                // One is positive current, zero negative, same on both coils
                COIL_A <= {dwr_s2_reg, ~dwr_s2_reg};
                COIL_B <= {dwr_s2_reg, ~dwr_s2_reg};
            end else begin
                COIL_A <= 6'h00;
                COIL_B <= 6'h00;
            end
        end
    end

    // Mark check and frame counting
    ttm_mark_check u_mark (
        .clk           (CLK_SYS),
        .rst           (SYS_RST),
        .frame_en      (TIMING_NEG), // Aligned with the mark shift just taken
        .mark_code     (MARK_CODE),
        .mark_ok_reg   (mark_ok),
        .frame_cnt_reg (frame_cnt)
    );

    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            MARK_VALID  <= 1'b0;
            FRAME_COUNT <= 3'h0;
        end else begin
            MARK_VALID  <= mark_ok;
            FRAME_COUNT <= frame_cnt;
        end
    end
endmodule

// >>> ttm_top_asserts.sv
// Assertion checker for the transport motion and format block
`timescale 1ns/1ns
module ttm_top_asserts (
    input wire       CLK_SYS,       // Clock
    input wire       SYS_RST,       // Reset
    input wire       MODE_LOCAL,    // Local
    input wire [1:0] JOG_SWITCH,    // Jog
    input wire       WRITE_ENABLE,  // Permit
    input wire [5:0] COIL_A,        // Coil A
    input wire [5:0] COIL_B,        // Coil B
    input wire       WRITE_ECHO,    // Echo
    input wire       MOTION_ACTIVE, // Motion
    input wire       DIRECTION_FWD, // Direction
    input wire       FWD_RUN,       // Run fwd
    input wire       FWD_DRAG,      // Drag fwd
    input wire       FWD_BRAKE,     // Brake fwd
    input wire       REV_RUN,       // Run rev
    input wire       REV_DRAG,      // Drag rev
    input wire       REV_BRAKE      // Brake rev
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // Jog held long enough to pass the synchronisers
    sequence s_jog_fwd; (MODE_LOCAL && JOG_SWITCH == 2'h1)[*5]; endsequence
    sequence s_remote; !MODE_LOCAL[*4] ##0 !MOTION_ACTIVE; endsequence
    sequence s_idle; !MOTION_ACTIVE[*2] ##0 !(FWD_BRAKE || REV_BRAKE); endsequence
    property p_jog_fwd; s_jog_fwd |-> MOTION_ACTIVE && DIRECTION_FWD; endproperty
    property p_local; s_remote |=> !MOTION_ACTIVE; endproperty
    property p_fwd; MOTION_ACTIVE && DIRECTION_FWD |-> FWD_RUN && REV_DRAG; endproperty
    property p_rev; MOTION_ACTIVE && !DIRECTION_FWD |-> REV_RUN && FWD_DRAG; endproperty
    property p_one_run; !(FWD_RUN && REV_RUN); endproperty
    property p_brake; $fell(MOTION_ACTIVE) |-> ##[0:1]
        (DIRECTION_FWD ? REV_BRAKE && !FWD_BRAKE : FWD_BRAKE && !REV_BRAKE); endproperty
    property p_idle; s_idle |-> FWD_DRAG && REV_DRAG; endproperty
    property p_echo; $stable(WRITE_ENABLE)[*4] |-> WRITE_ECHO == WRITE_ENABLE; endproperty
    property p_coil; COIL_A == COIL_B; endproperty
    a_jog_fwd: assert property (p_jog_fwd) else $error("jog fwd");
    a_local: assert property (p_local) else $error("remote move");
    a_fwd: assert property (p_fwd) else $error("fwd drive");
    a_rev: assert property (p_rev) else $error("rev drive");
    a_one_run: assert property (p_one_run) else $error("two runs");
    a_brake: assert property (p_brake) else $error("brake side");
    a_idle: assert property (p_idle) else $error("idle drag");
    a_echo: assert property (p_echo) else $error("echo");
    a_coil: assert property (p_coil) else $error("coil pair");
endmodule
bind ttm_top ttm_top_asserts u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .MODE_LOCAL(MODE_LOCAL), .JOG_SWITCH(JOG_SWITCH), .WRITE_ENABLE(WRITE_ENABLE),
    .COIL_A(COIL_A), .COIL_B(COIL_B), .WRITE_ECHO(WRITE_ECHO),
    .MOTION_ACTIVE(MOTION_ACTIVE), .DIRECTION_FWD(DIRECTION_FWD), .FWD_RUN(FWD_RUN),
    .FWD_DRAG(FWD_DRAG), .FWD_BRAKE(FWD_BRAKE), .REV_RUN(REV_RUN),
    .REV_DRAG(REV_DRAG), .REV_BRAKE(REV_BRAKE));

// >>> ttm_tape_model.sv
// Tape head model sending one six-frame word
`timescale 1ns/1ns
module ttm_tape_model (
    input  wire       go,     // Start a word
    input  wire [5:0] code,   // Mark code
    input  wire [2:0] dval,   // Frame data
    output reg        timing, // Timing channel
    output reg        mark,   // Mark channel
    output reg  [2:0] data    // Data channels
);
    integer k;
    // Timing stands still outside a word
    initial begin
        timing = 1'b0;
        mark = 1'b0;
        data = 3'h0;
    end
    // Rise brings the next frame, fall is the read strobe; released lines invert
    always @(posedge go) begin
        for (k = 0; k < 6; k = k + 1) begin
            #62 timing = 1'b1;
            mark = code[5 - k];
            data = dval;
            #63 timing = 1'b0;
        end
        #63 mark = ~mark;
        data = ~dval;
    end
endmodule

// >>> tape_transport_motion_and_format_tb_top.sv
// Self-checking bench for the transport motion and format block
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module tape_transport_motion_and_format_tb_top;
    reg        clk, rst, loc, wen, wmd, go;
    reg  [1:0] jog;
    reg  [2:0] dwr;
    wire       tim, mrk, echo, tp, tn, mot, dfw, frun, fdrg, fbrk, rrun, rdrg, rbrk;
    wire       mval;
    wire [2:0] din, dout, fcnt;
    wire [5:0] mcode, ca, cb;
    integer    fails, total_checks, cycles, np, nn;
    ttm_tape_model head (.go(go), .code(6'h07), .dval(3'h6), .timing(tim),
        .mark(mrk), .data(din));
    ttm_top uut (.CLK_SYS(clk), .SYS_RST(rst), .MODE_LOCAL(loc), .JOG_SWITCH(jog),
        .WRITE_ENABLE(wen), .WRITE_MODE(wmd), .TIMING_IN(tim), .MARK_IN(mrk),
        .DATA_IN(din), .DATA_WR(dwr), .WRITE_ECHO(echo), .TIMING_POS(tp),
        .TIMING_NEG(tn), .DATA_OUT(dout), .MARK_CODE(mcode), .MARK_VALID(mval),
        .FRAME_COUNT(fcnt), .COIL_A(ca), .COIL_B(cb), .MOTION_ACTIVE(mot),
        .DIRECTION_FWD(dfw), .FWD_RUN(frun), .FWD_DRAG(fdrg), .FWD_BRAKE(fbrk),
        .REV_RUN(rrun), .REV_DRAG(rdrg), .REV_BRAKE(rbrk));
    // Clock, timeout and timing pulse counters
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        np = np + (tp === 1'b1);
        nn = nn + (tn === 1'b1);
        if (cycles == 2000) begin
            fails++;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // Echo follows the permit switch; remote jog ignored; idle drags both
    task t_static;
        begin
            `CHK("drag", 2'h3, {fdrg, rdrg})
            `CHK("echo", 1'b0, echo)
            wen = 1'b1; jog = 2'h1; cyc(8);
            `CHK("echo", 1'b1, echo)
            `CHK("motion", 1'b0, mot)
            jog = 2'h0; loc = 1'b1; cyc(8);
            `CHK("idle", 4'hc, {fdrg, rdrg, fbrk, rbrk})
        end
    endtask
    // Forward, hold, reverse, hold
    task t_motion;
        begin
            jog = 2'h1; cyc(6);
            `CHK("fwd", 5'h1d, {mot, dfw, frun, rrun, rdrg})
            jog = 2'h0; cyc(6);
            `CHK("hold", 3'h1, {mot, fbrk, rbrk})
            jog = 2'h2; cyc(6);
            `CHK("rev", 5'h13, {mot, dfw, frun, rrun, fdrg})
            jog = 2'h0; cyc(6);
            `CHK("hold", 3'h2, {mot, fbrk, rbrk})
        end
    endtask
    // Coil pairs carry the same data only while writing is permitted
    task t_write;
        begin
            wmd = 1'b1; dwr = 3'h5; cyc(6);
            `CHK("coil", 12'haaa, {ca, cb})
            wen = 1'b0; cyc(6);
            `CHK("coil", 6'h00, ca)
            wen = 1'b1; wmd = 1'b0;
        end
    endtask
    // One word from tape: six pulse pairs, mark code and frame data
    task t_tape;
        begin
            np = 0; nn = 0; go = 1'b1; cyc(2);
            go = 1'b0; cyc(98);
            `CHK("pulses", 16'h0606, {np[7:0], nn[7:0]})
            `CHK("mark", 6'h07, mcode)
            `CHK("data", 3'h6, dout)
            `CHK("mark ok", 1'b1, mval)
            `CHK("frames", 3'h0, fcnt)
        end
    endtask
    initial begin
        rst = 1'b1; loc = 1'b0; jog = 2'h0; wen = 1'b0; wmd = 1'b0; go = 1'b0; dwr = 3'h0;
        fails = 0; total_checks = 0; cycles = 0; np = 0; nn = 0;
        cyc(10);
        rst = 1'b0;
        cyc(4);
        t_static;
        t_motion;
        t_write;
        t_tape;
        end_of_test;
    end
endmodule
